/* File: rtl/abu_alu_branch.sv */
`default_nettype none
// How it works
// (RULE_01) Add registers, optional carry, all five flags
// (RULE_02) Subtract register, optional carry, all five flags
// (RULE_03) Subtract immediate, optional carry, five flags
// (RULE_04) AND, OR, XOR touch Z, N, V only
// (RULE_05) Set bits ORs mask, Z N V
// (RULE_06) Clear bits ANDs with FFh minus mask
// (RULE_07) Test ANDs register with itself, Z N V
// (RULE_08) Compares set five flags, discard difference
// (RULE_09) Skip on equal registers, one or two cycles
// (RULE_10) Skip on register bit clear or set
// (RULE_11) Skip on I/O bit clear or set
// (RULE_12) Flag branch loads PC plus offset plus one
// (RULE_13) Signed greater-equal taken when N xor V zero
// (RULE_14) Same-higher is carry clear, lower carry set
// (RULE_15) Half-carry branches on H set or clear
// (RULE_16) Overflow-set branch taken when V is one
// (RULE_17) T-flag branches on T set or clear
// (RULE_18) Interrupt-enabled branch taken when I is one
// (RULE_19) Signed less-than taken when N xor V one
// (RULE_20) Overflow-clear branch taken when V is zero
module abu_alu_branch (
    input wire logic MCLK_I, // Core clock
    input wire logic RST_N_I, // Synchronous reset, active low
    input wire logic OP_VALID_I, // Operation offered
    output logic OP_READY_O, // Operation can be taken
    input wire logic [5:0] OP_CODE_I, // Operation code
    input wire logic [7:0] OP_DST_I, // Destination register value
    input wire logic [7:0] OP_SRC_I, // Source register or immediate
    input wire logic [7:0] OP_IO_I, // Selected I/O register value
    input wire logic [2:0] OP_BIT_I, // Bit or flag select
    input wire logic [6:0] OP_OFFSET_I, // Signed branch offset
    input wire logic OP_NEXT_LONG_I, // Next instruction is two words
    input wire logic [11:0] PC_I, // Address of this instruction
    output logic [7:0] RES_O, // Result value
    output logic RES_WE_O, // Write result to destination
    output logic [7:0] STATUS_O, // Status register
    output logic [11:0] PC_O, // Next program counter
    output logic PC_LOAD_O, // Load PC_O into the program counter
    output logic DONE_O, // Operation finished
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [3:0] WB_ADR_I, // Wishbone byte address
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
    input wire logic [31:0] WB_DAT_I, // Wishbone write data
    output logic [31:0] WB_DAT_O, // Wishbone read data
    output logic WB_ACK_O // Wishbone acknowledge
);
    // ------------------------------------------------------------
    // Flag helpers
    // ------------------------------------------------------------
    // Shared by every add, subtract and compare
    function automatic logic [7:0] arith_status(input logic [7:0] s, input logic [7:0] a,
                                                input logic [7:0] b, input logic [7:0] r,
                                                input logic c_out, input logic is_sub);
        logic [7:0] f;
        f = s;
        if (is_sub) begin
            f[abu_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            f[abu_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            f[abu_pkg::FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            f[abu_pkg::FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        f[abu_pkg::FLAG_N] = r[7];
        f[abu_pkg::FLAG_Z] = (r == 8'h00);
        f[abu_pkg::FLAG_C] = c_out;
        return f;
    endfunction : arith_status

    // Logic results clear V and leave C and H alone
    function automatic logic [7:0] logic_status(input logic [7:0] s, input logic [7:0] r);
        logic [7:0] f;
        f = s;
        f[abu_pkg::FLAG_V] = 1'b0;
        f[abu_pkg::FLAG_N] = r[7];
        f[abu_pkg::FLAG_Z] = (r == 8'h00);
        return f;
    endfunction : logic_status

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    abu_pkg::abu_state_t state_q;
    abu_pkg::abu_op_t op;
    logic [7:0] status_q, status_d, res_q, res_d;
    logic [11:0] pc_q, target_d, skip_pc, branch_pc;
    logic res_we_q, pc_load_q, done_q, ack_q;
    logic [31:0] rdata_q;
    logic write_d, jump_d, skip_d, branch_d, use_c, accept, bus_req;
    logic [8:0] sum, diff;
    logic [7:0] cin;

    assign accept = OP_VALID_I && OP_READY_O;
    // A taken skip or branch holds off the next operation for its second cycle
    assign OP_READY_O = (state_q == abu_pkg::ST_IDLE);
    assign skip_pc = PC_I + (OP_NEXT_LONG_I ? abu_pkg::SKIP_LONG : abu_pkg::SKIP_SHORT);
    assign branch_pc = PC_I + {{5{OP_OFFSET_I[6]}}, OP_OFFSET_I} + abu_pkg::BRANCH_BIAS; // RULE_12

    // ------------------------------------------------------------
    // Operation decode and datapath
    // ------------------------------------------------------------
    // One shared adder and subtractor serve the register and immediate forms
    always_comb begin
        op = abu_pkg::abu_op_t'(OP_CODE_I);
        use_c = (op == abu_pkg::OP_ADD_CARRY) || (op == abu_pkg::OP_SUBTRACT_WITH_CARRY) ||
                (op == abu_pkg::OP_SUBTRACT_CARRY_IMMEDIATE) ||
                (op == abu_pkg::OP_COMPARE_WITH_CARRY);
        cin = {7'h00, use_c & status_q[abu_pkg::FLAG_C]};
        sum = {1'b0, OP_DST_I} + {1'b0, OP_SRC_I} + {1'b0, cin};
        diff = {1'b0, OP_DST_I} - {1'b0, OP_SRC_I} - {1'b0, cin};
        res_d = res_q;
        status_d = status_q;
        write_d = 1'b0;
        skip_d = 1'b0;
        branch_d = 1'b0;
        unique case (op)
            abu_pkg::OP_ADD, abu_pkg::OP_ADD_CARRY: begin
                res_d = sum[7:0]; // RULE_01
                write_d = 1'b1;
                status_d = arith_status(status_q, OP_DST_I, OP_SRC_I, sum[7:0], sum[8], 1'b0);
            end
            abu_pkg::OP_SUB, abu_pkg::OP_SUBTRACT_WITH_CARRY, abu_pkg::OP_SUBTRACT_IMMEDIATE,
            abu_pkg::OP_SUBTRACT_CARRY_IMMEDIATE: begin
                res_d = diff[7:0]; // RULE_02 RULE_03
                write_d = 1'b1;
                status_d = arith_status(status_q, OP_DST_I, OP_SRC_I, diff[7:0], diff[8], 1'b1);
            end
            abu_pkg::OP_COMPARE, abu_pkg::OP_COMPARE_WITH_CARRY,
            abu_pkg::OP_COMPARE_IMMEDIATE: begin
                // Difference only feeds the flags
                status_d = arith_status(status_q, OP_DST_I, OP_SRC_I, diff[7:0], diff[8], 1'b1); // RULE_08
            end
            abu_pkg::OP_AND, abu_pkg::OP_AND_IMMEDIATE: begin
                res_d = OP_DST_I & OP_SRC_I; // RULE_04
                write_d = 1'b1;
                status_d = logic_status(status_q, res_d);
            end
            abu_pkg::OP_OR, abu_pkg::OP_OR_IMMEDIATE, abu_pkg::OP_SET_BITS: begin
                res_d = OP_DST_I | OP_SRC_I; // RULE_04 RULE_05
                write_d = 1'b1;
                status_d = logic_status(status_q, res_d);
            end
            abu_pkg::OP_EXCLUSIVE_OR: begin
                res_d = OP_DST_I ^ OP_SRC_I; // RULE_04
                write_d = 1'b1;
                status_d = logic_status(status_q, res_d);
            end
            abu_pkg::OP_CLEAR_BITS: begin
                res_d = OP_DST_I & (abu_pkg::ALL_ONES - OP_SRC_I); // RULE_06
                write_d = 1'b1;
                status_d = logic_status(status_q, res_d);
            end
            abu_pkg::OP_TEST_ZERO_MINUS: begin
                res_d = OP_DST_I & OP_DST_I; // RULE_07
                write_d = 1'b1;
                status_d = logic_status(status_q, res_d);
            end
            abu_pkg::OP_COMPARE_SKIP_EQUAL: skip_d = (OP_DST_I == OP_SRC_I); // RULE_09
            abu_pkg::OP_SKIP_REG_BIT_CLEAR: skip_d = ~OP_DST_I[OP_BIT_I]; // RULE_10
            abu_pkg::OP_SKIP_REG_BIT_SET: skip_d = OP_DST_I[OP_BIT_I]; // RULE_10
            abu_pkg::OP_SKIP_IO_BIT_CLEAR: skip_d = ~OP_IO_I[OP_BIT_I]; // RULE_11
            abu_pkg::OP_SKIP_IO_BIT_SET: skip_d = OP_IO_I[OP_BIT_I]; // RULE_11
            abu_pkg::OP_BRANCH_FLAG_SET: branch_d = status_q[OP_BIT_I]; // RULE_12
            abu_pkg::OP_BRANCH_FLAG_CLEAR: branch_d = ~status_q[OP_BIT_I]; // RULE_12
            abu_pkg::OP_BRANCH_SIGNED_GE: begin
                branch_d = ~(status_q[abu_pkg::FLAG_N] ^ status_q[abu_pkg::FLAG_V]); // RULE_13
            end
            abu_pkg::OP_BRANCH_SIGNED_LT: begin
                branch_d = status_q[abu_pkg::FLAG_N] ^ status_q[abu_pkg::FLAG_V]; // RULE_19
            end
            abu_pkg::OP_BRANCH_SAME_HIGHER: branch_d = ~status_q[abu_pkg::FLAG_C]; // RULE_14
            abu_pkg::OP_BRANCH_LOWER: branch_d = status_q[abu_pkg::FLAG_C]; // RULE_14
            abu_pkg::OP_BRANCH_HALF_CARRY_SET: branch_d = status_q[abu_pkg::FLAG_H]; // RULE_15
            abu_pkg::OP_BRANCH_HALF_CARRY_CLEAR: branch_d = ~status_q[abu_pkg::FLAG_H]; // RULE_15
            abu_pkg::OP_BRANCH_TRANSFER_SET: branch_d = status_q[abu_pkg::FLAG_T]; // RULE_17
            abu_pkg::OP_BRANCH_TRANSFER_CLEAR: branch_d = ~status_q[abu_pkg::FLAG_T]; // RULE_17
            abu_pkg::OP_BRANCH_OVERFLOW_SET: branch_d = status_q[abu_pkg::FLAG_V]; // RULE_16
            abu_pkg::OP_BRANCH_OVERFLOW_CLEAR: branch_d = ~status_q[abu_pkg::FLAG_V]; // RULE_20
            abu_pkg::OP_BRANCH_IRQ_ENABLED: branch_d = status_q[abu_pkg::FLAG_I]; // RULE_18
            default: begin
                // Undefined codes act as a one-cycle no-op
                res_d = res_q;
            end
        endcase
        jump_d = skip_d || branch_d;
        target_d = skip_d ? skip_pc : branch_pc;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Second cycle only for a taken skip or branch
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state_q <= abu_pkg::ST_IDLE;
        end else if (accept && jump_d) begin
            state_q <= abu_pkg::ST_SECOND; // RULE_09 RULE_12
        end else begin
            state_q <= abu_pkg::ST_IDLE;
        end
    end

    // Result and write strobe
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            res_q <= 8'h00;
            res_we_q <= 1'b0;
        end else begin
            res_we_q <= accept && write_d;
            if (accept && write_d) begin
                res_q <= res_d;
            end
        end
    end

    // Status register; bus writes land at the ack edge, op flags win
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            status_q <= abu_pkg::STATUS_RST;
        end else if (accept) begin
            status_q <= status_d;
        end else if (WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && WB_SEL_I[0] &&
                     WB_ADR_I == abu_pkg::REG_STATUS) begin
            status_q <= WB_DAT_I[7:0];
        end
    end

    // Program counter load and completion
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            pc_q <= 12'h000;
            pc_load_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (accept && jump_d) begin
                pc_q <= target_d;
            end
            pc_load_q <= (state_q == abu_pkg::ST_SECOND);
            done_q <= (accept && !jump_d) || (state_q == abu_pkg::ST_SECOND);
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // One wait state; unmapped addresses acknowledge and read zero
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            unique case (WB_ADR_I)
                abu_pkg::REG_STATUS: rdata_q <= {24'h000000, status_q};
                abu_pkg::REG_RESULT: rdata_q <= {24'h000000, res_q};
                abu_pkg::REG_TARGET: rdata_q <= {20'h00000, pc_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign RES_O = res_q;
    assign RES_WE_O = res_we_q;
    assign STATUS_O = status_q;
    assign PC_O = pc_q;
    assign PC_LOAD_O = pc_load_q;
    assign DONE_O = done_q;
    assign WB_DAT_O = rdata_q;
    assign WB_ACK_O = ack_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    AST_ADD_SUM: assert property (accept && op == abu_pkg::OP_ADD |=> RES_WE_O && // RULE_01
        RES_O == 8'($past(OP_DST_I) + $past(OP_SRC_I)))
        else $error("add result wrong");
    AST_SUB_CARRY: assert property (accept && op == abu_pkg::OP_SUBTRACT_WITH_CARRY |=> // RULE_02
        RES_O == 8'($past(OP_DST_I) - $past(OP_SRC_I) - $past(STATUS_O[0])))
        else $error("subtract with carry wrong");
    AST_SUBTRACT_IMMEDIATE_BORROW: assert property (accept && op == abu_pkg::OP_SUBTRACT_IMMEDIATE |=> // RULE_03
        STATUS_O[abu_pkg::FLAG_C] == ($past(OP_SRC_I) > $past(OP_DST_I)))
        else $error("immediate borrow wrong");
    AST_LOGIC_KEEP_C: assert property (accept && (op == abu_pkg::OP_EXCLUSIVE_OR || // RULE_04
        op == abu_pkg::OP_AND) |=> $stable(STATUS_O[abu_pkg::FLAG_C]) &&
        !STATUS_O[abu_pkg::FLAG_V])
        else $error("logic op disturbed carry or overflow");
    AST_CLEAR_BITS: assert property (accept && op == abu_pkg::OP_CLEAR_BITS |=> // RULE_06
        RES_O == ($past(OP_DST_I) & ~$past(OP_SRC_I)))
        else $error("clear bits wrong");
    AST_TEST: assert property (accept && op == abu_pkg::OP_TEST_ZERO_MINUS |=> // RULE_07
        RES_O == $past(OP_DST_I) && STATUS_O[abu_pkg::FLAG_N] == $past(OP_DST_I[7]))
        else $error("test result wrong");
    AST_CMP_NO_WRITE: assert property (accept && op == abu_pkg::OP_COMPARE |=> // RULE_08
        !RES_WE_O && STATUS_O[abu_pkg::FLAG_Z] == ($past(OP_DST_I) == $past(OP_SRC_I)))
        else $error("compare wrote or zero flag wrong");
    AST_SKIP_TWO: assert property (accept && op == abu_pkg::OP_COMPARE_SKIP_EQUAL && // RULE_09
        OP_DST_I == OP_SRC_I |=> !DONE_O && !OP_READY_O &&
        PC_O == 12'($past(PC_I) + ($past(OP_NEXT_LONG_I) ? 12'h003 : 12'h002))
        ##1 DONE_O && PC_LOAD_O)
        else $error("skip timing or target wrong");
    AST_NOSKIP_ONE: assert property (accept && op == abu_pkg::OP_COMPARE_SKIP_EQUAL && // RULE_09
        OP_DST_I != OP_SRC_I |=> DONE_O && !PC_LOAD_O)
        else $error("untaken skip not one cycle");
    AST_GE_TAKEN: assert property (accept && op == abu_pkg::OP_BRANCH_SIGNED_GE && // RULE_13
        !(STATUS_O[abu_pkg::FLAG_N] ^ STATUS_O[abu_pkg::FLAG_V]) |-> ##2 PC_LOAD_O)
        else $error("signed ge not taken");
    AST_LT_TAKEN: assert property (accept && op == abu_pkg::OP_BRANCH_SIGNED_LT |-> // RULE_19
        ##2 (PC_LOAD_O == $past(STATUS_O[abu_pkg::FLAG_N] ^ STATUS_O[abu_pkg::FLAG_V], 2)))
        else $error("signed lt decision wrong");
    AST_VC_TAKEN: assert property (accept && op == abu_pkg::OP_BRANCH_OVERFLOW_CLEAR |-> // RULE_20
        ##2 (PC_LOAD_O == !$past(STATUS_O[abu_pkg::FLAG_V], 2)))
        else $error("overflow clear decision wrong");

    COV_BRANCH_TAKEN: cover property (accept && branch_d ##1 !DONE_O ##1 PC_LOAD_O);
    COV_SKIP_LONG: cover property (accept && skip_d && OP_NEXT_LONG_I);
    COV_ADD_CARRY_OUT: cover property (accept && op == abu_pkg::OP_ADD_CARRY && sum[8]);
    COV_BUS_WRITE: cover property (WB_ACK_O && WB_WE_I && WB_ADR_I == abu_pkg::REG_STATUS);
endmodule : abu_alu_branch
`default_nettype wire

/* File: rtl/abu_pkg.sv */
`default_nettype none
package abu_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int OFS_W = 7;
    localparam int ADR_W = 4;

    // ------------------------------------------------------------
    // Status register bit positions and reset value
    // ------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // ------------------------------------------------------------
    // Program counter steps
    // ------------------------------------------------------------
    localparam logic [11:0] SKIP_SHORT = 12'h002;
    localparam logic [11:0] SKIP_LONG = 12'h003;
    localparam logic [11:0] BRANCH_BIAS = 12'h001;

    // ------------------------------------------------------------
    // Wishbone register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_TARGET = 4'h8;

    // ------------------------------------------------------------
    // Operations and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY,
        OP_SUBTRACT_CARRY_IMMEDIATE, OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE,
        OP_EXCLUSIVE_OR, OP_SET_BITS, OP_CLEAR_BITS, OP_TEST_ZERO_MINUS, OP_COMPARE,
        OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE, OP_COMPARE_SKIP_EQUAL,
        OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_SAME_HIGHER,
        OP_BRANCH_LOWER, OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
        OP_BRANCH_TRANSFER_SET, OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVERFLOW_SET,
        OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED
    } abu_op_t;

    typedef enum logic {ST_IDLE, ST_SECOND} abu_state_t;
endpackage : abu_pkg
`default_nettype wire

/* File: sim/abu_core_model.sv */
`default_nettype none
// ------------------------------------------------------------
// Register file and program counter stand-in
// ------------------------------------------------------------
module abu_core_model (
    input wire logic clk_i, // Core clock
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire logic [7:0] res_i, // Result from the unit
    input wire logic res_we_i, // Result write strobe
    input wire logic [11:0] pc_i, // Target from the unit
    input wire logic pc_load_i, // Target load strobe
    output logic [7:0] rd_o, // Destination register copy
    output logic [11:0] pc_o // Program counter copy
);
    timeunit 1ns;
    timeprecision 1ps;
    // Write back only on the strobe, so a stray compare write shows up here
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_o <= 8'h00;
        end else if (res_we_i) begin
            rd_o <= res_i;
        end
    end
    // Program counter moves only on a load, so a missing pulse is seen
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_o <= 12'h000;
        end else if (pc_load_i) begin
            pc_o <= pc_i;
        end
    end
endmodule : abu_core_model
`default_nettype wire

/* File: sim/test_alu_and_branch_unit.sv */
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_alu_and_branch_unit;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus, outputs and expectations
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, lng = 1'b0, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
    logic [5:0] opc = 6'h00;
    logic [7:0] dst = 8'h00, src = 8'h00, io = 8'h00;
    logic [2:0] bsel = 3'h0;
    logic [6:0] ofs = 7'h00;
    logic [11:0] pc = 12'h000;
    logic [3:0] adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic rdy, res_we, pc_ld, done, ack;
    logic [7:0] res, st, m_rd;
    logic [11:0] pco, m_pc;
    logic [31:0] rdat;
    logic [7:0] e_st = 8'h00, e_rd = 8'h00, e_res = 8'h00;
    logic [11:0] e_pc = 12'h000;
    int n_fail = 0;
    int check_count = 0;
    abu_alu_branch dut (.MCLK_I(clk), .RST_N_I(rst_n), .OP_VALID_I(vld), .OP_READY_O(rdy),
        .OP_CODE_I(opc), .OP_DST_I(dst), .OP_SRC_I(src), .OP_IO_I(io), .OP_BIT_I(bsel),
        .OP_OFFSET_I(ofs), .OP_NEXT_LONG_I(lng), .PC_I(pc), .RES_O(res), .RES_WE_O(res_we),
        .STATUS_O(st), .PC_O(pco), .PC_LOAD_O(pc_ld), .DONE_O(done), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack));
    abu_core_model core (.clk_i(clk), .rst_n_i(rst_n), .res_i(res), .res_we_i(res_we),
        .pc_i(pco), .pc_load_i(pc_ld), .rd_o(m_rd), .pc_o(m_pc));
    initial begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Reference models and bus tasks
    // ------------------------------------------------------------
    // Opcodes follow the enum order of the package
    function automatic logic [15:0] alu_ref(input int o, input logic [7:0] a, b, s);
        logic [8:0] r;
        logic c, h, v, sb, lg;
        sb = o inside {[2:5], [14:16]};
        lg = o inside {[6:13]};
        c = (o inside {1, 4, 5, 15}) ? s[0] : 1'b0;
        r = sb ? {1'b0, a} - {1'b0, b} - {8'h00, c} : {1'b0, a} + {1'b0, b} + {8'h00, c};
        case (o)
            6, 7: r[7:0] = a & b;
            8, 9, 11: r[7:0] = a | b;
            10: r[7:0] = a ^ b;
            12: r[7:0] = a & (8'hFF - b);
            13: r[7:0] = a & a;
            default: ;
        endcase
        h = sb ? (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3])
               : (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        v = sb ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])
               : (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        s[1] = r[7:0] == 8'h00;
        s[2] = r[7];
        s[3] = lg ? 1'b0 : v;
        if (!lg) begin
            s[0] = r[8];
            s[5] = h;
        end
        return {r[7:0], s};
    endfunction : alu_ref
    function automatic logic tk(input int o, input logic [7:0] d, s, i, f, input logic [2:0] b);
        case (o)
            17: return d == s;
            18: return !d[b];
            19: return d[b];
            20: return !i[b];
            21: return i[b];
            22: return f[b];
            23: return !f[b];
            24: return !(f[2] ^ f[3]);
            25: return f[2] ^ f[3];
            26: return !f[0];
            27: return f[0];
            28: return f[5];
            29: return !f[5];
            30: return f[6];
            31: return !f[6];
            32: return f[3];
            33: return !f[3];
            default: return f[7];
        endcase
    endfunction : tk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // Classic single cycle; ack is read as it stood just before the edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = rdat;
        `CHK("bus_ack", 1, int'(i < 8))
        if (i == 8) end_of_test();
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // One op; one idle edge at the end lets the core model catch its strobes
    task automatic run_op(input int o, input logic [7:0] d, s, output int n,
                          output logic ld, w, r);
        opc <= 6'(o);
        dst <= d;
        src <= s;
        pc <= 12'hFFE;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        n = 0;
        w = 1'b0;
        ld = 1'b0;
        r = 1'b1;
        while (n < 4) begin
            @(posedge clk);
            n++;
            if (n == 1) r = rdy;
            w = w | res_we;
            if (done === 1'b1) break;
        end
        ld = pc_ld;
        `CHK("op_done", 1, int'(n < 4))
        if (n == 4) end_of_test();
        @(posedge clk);
    endtask : run_op
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_arith();
        logic [7:0] a[3] = '{8'h7F, 8'h00, 8'h88};
        logic [7:0] b[3] = '{8'h01, 8'h01, 8'h88};
        logic [7:0] si[3] = '{8'h31, 8'h00, 8'h01};
        logic [15:0] r;
        logic [31:0] q;
        int n;
        logic ld, w, rd;
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, 4'h0, {24'h0, si[p]}, q);
            e_st = si[p];
            for (int o = 0; o < 17; o++) begin
                r = alu_ref(o, a[p], b[p], e_st);
                run_op(o, a[p], b[p], n, ld, w, rd);
                `CHK("cycles", 1, n)
                `CHK("status", r[7:0], st)
                `CHK("write", o < 14, w)
                if (o < 14) e_rd = r[15:8];
                if (o < 14) e_res = r[15:8];
                `CHK("result", e_res, res)
                `CHK("dest_reg", e_rd, m_rd)
                e_st = r[7:0];
            end
        end
        $display("test arith done");
    endtask : t_arith
    task automatic t_branch();
        logic [7:0] sv[3] = '{8'h00, 8'hED, 8'h09};
        logic [31:0] q;
        logic [7:0] s;
        logic [6:0] k;
        int n;
        logic ld, w, rd, t;
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, 4'h0, {24'h0, sv[p]}, q);
            e_st = sv[p];
            k = p[0] ? 7'h7C : 7'h05;
            s = (p == 1) ? 8'h5A : 8'h5B;
            for (int o = 17; o < 35; o++) begin
                io <= 8'hA5;
                bsel <= 3'(p);
                ofs <= k;
                lng <= p[0];
                t = tk(o, 8'h5A, s, 8'hA5, e_st, 3'(p));
                run_op(o, 8'h5A, s, n, ld, w, rd);
                `CHK("cycles", t ? 2 : 1, n)
                `CHK("pc_load", t, ld)
                `CHK("ready", !t, rd)
                `CHK("write", 1'b0, w)
                `CHK("status", e_st, st)
                if (t && o < 22) e_pc = 12'hFFE + (p[0] ? 12'h003 : 12'h002);
                if (t && o > 21) e_pc = 12'hFFE + {{5{k[6]}}, k} + 12'h001;
                `CHK("target", e_pc, pco)
                `CHK("core_pc", e_pc, m_pc)
            end
        end
        $display("test branch done");
    endtask : t_branch
    // Read-only result place must not take writes; unmapped place reads zero
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, 4'h0, 32'h0, q);
        `CHK("rd_status", {24'h0, e_st}, q)
        wb(1'b1, 4'h4, 32'h0000_00AA, q);
        wb(1'b0, 4'h4, 32'h0, q);
        `CHK("rd_result", {24'h0, e_res}, q)
        wb(1'b0, 4'h8, 32'h0, q);
        `CHK("rd_target", {20'h0, e_pc}, q)
        wb(1'b0, 4'hC, 32'h0, q);
        `CHK("rd_unmapped", 32'h0, q)
        $display("test regs done");
    endtask : t_regs
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("rst_status", 8'h00, st)
        `CHK("rst_target", 12'h000, pco)
        t_arith();
        t_branch();
        t_regs();
        end_of_test();
    end
endmodule : test_alu_and_branch_unit
`undef CHK
`default_nettype wire
